/* File: verilog/scss_sequencer.sv */
// Session sequencer: activation, deactivation, fault status, shutdown.
// Assumes synchronous inputs; analog comparators report as levels.
`timescale 1ns/1ps
`default_nettype none
module scss_sequencer
   import scss_pkg::*;
// Oscillator divider end counts; smaller values shorten every period
// while all sequence counts stay as they are, which keeps runs quick
#(
   parameter logic [10:0] SLOW_LAST = SLOW_DIV_LAST,
   parameter logic [10:0] FAST_LAST = FAST_DIV_LAST
)
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic session_request_n_i,
   input wire logic card_present_n_i,
   input wire logic overcurrent_i,
   input wire logic [2:0] supply_drop_i,
   input wire logic overtemp_i,
   input wire logic vcc_below_i,
   output logic osc_fast_o,
   output logic card_vcc_en_o,
   output logic card_rst_en_o,
   output logic card_clk_en_o,
   output logic contacts_grounded_o,
   output logic host_io_line_o,
   output logic host_io_line_oe_o,
   output logic host_aux1_line_o,
   output logic host_aux1_line_oe_o,
   output logic host_aux2_line_o,
   output logic host_aux2_line_oe_o,
   output logic fault_status_n_o
);
   typedef struct packed {
      scss_state_t st;
      logic [10:0] cnt;
      logic [10:0] sdiv;
      logic [10:0] fdiv;
      logic [10:0] oc_cnt;
      logic req_n;
      logic fault;
      logic fault_n;
      logic osc_fast;
      logic vcc_en;
      logic rst_en;
      logic clk_en;
      logic line_oe;
      logic line_lvl;
      logic grounded;
   } scss_seq_t;

   localparam scss_seq_t SEQ_RST = '{st: S_HOLD, cnt: 11'h000,
      sdiv: 11'h000, fdiv: 11'h000, oc_cnt: 11'h000, req_n: 1'b1,
      fault: 1'b0, fault_n: 1'b0, osc_fast: 1'b0, vcc_en: 1'b0,
      rst_en: 1'b0, clk_en: 1'b0, line_oe: 1'b0, line_lvl: 1'b1,
      grounded: 1'b1};

   scss_seq_t s_q;
   scss_seq_t s_d;
   logic slow_tick;
   logic fast_tick;
   logic osc_tick;
   logic present;
   logic session;
   logic fault_cond;
   logic abort;
   logic [10:0] cnt_nx;

   scss_debounce u_debounce (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .tick_i(slow_tick),
      .card_present_n_i(card_present_n_i),
      .present_o(present)
   );

   // Oscillator model: two dividers, the sequencer picks the active one
   assign slow_tick = (s_q.sdiv == SLOW_LAST);
   assign fast_tick = (s_q.fdiv == FAST_LAST);
   assign osc_tick = s_q.osc_fast ? fast_tick : slow_tick;
   assign cnt_nx = s_q.cnt + 11'h001;
   assign session = (s_q.st == S_WAKE) || (s_q.st == S_ACT);
   // Removal, filtered overload, any supply drop, overheat
   assign fault_cond = !present || (s_q.oc_cnt == OC_FILT) ||
      (|supply_drop_i) || overtemp_i; // [R14]
   assign abort = session && (session_request_n_i || fault_cond);

   always_comb
   begin
      s_d = s_q;
      s_d.sdiv = slow_tick ? 11'h000 : s_q.sdiv + 11'h001;
      s_d.fdiv = fast_tick ? 11'h000 : s_q.fdiv + 11'h001;
      s_d.req_n = session_request_n_i;
      // Overload must persist before it counts; unseen outside a session
      if (!overcurrent_i || !session)
         s_d.oc_cnt = '0; // [R16]
      else if (slow_tick && s_q.oc_cnt != OC_FILT)
         s_d.oc_cnt = s_q.oc_cnt + 11'h001; // [R13]
      // Fault latch: set wins, cleared only once request is released
      if (session && !session_request_n_i && fault_cond)
         s_d.fault = 1'b1; // [R17]
      else if (session_request_n_i && !session)
         s_d.fault = 1'b0; // [R18]
      unique case (s_q.st)
         S_HOLD:
         begin
            if (slow_tick)
            begin
               s_d.cnt = cnt_nx;
               if (s_q.cnt == HOLD_LAST)
                  s_d.st = S_IDLE; // [R22]
            end
         end
         S_IDLE:
         begin
            if (|supply_drop_i)
            begin
               s_d.st = S_HOLD; // [R16]
               s_d.cnt = '0;
            end
            else if (s_q.req_n && !session_request_n_i)
            begin
               s_d.st = S_WAKE; // [R1]
               s_d.cnt = '0;
            end
         end
         S_WAKE, S_ACT:
         begin
            if (abort)
            begin
               // Same counter restarts for the way back down
               s_d.st = S_DEACT; // [R7] [R23]
               s_d.cnt = '0;
               s_d.osc_fast = 1'b1;
            end
            else if (osc_tick && s_q.st == S_WAKE)
            begin
               s_d.cnt = cnt_nx;
               if (s_q.cnt == WAKE_LAST)
               begin
                  s_d.st = S_ACT; // [R1]
                  s_d.cnt = '0;
                  s_d.osc_fast = 1'b1; // [R5]
                  s_d.vcc_en = 1'b1; // [R2]
                  s_d.grounded = 1'b0;
               end
            end
            else if (osc_tick && s_q.cnt != ACT_RST)
            begin
               s_d.cnt = cnt_nx; // [R23]
               if (cnt_nx == ACT_LINES)
               begin
                  s_d.line_oe = 1'b1; // [R3]
                  s_d.line_lvl = 1'b1;
                  s_d.clk_en = 1'b1; // [R6]
               end
               if (cnt_nx == ACT_RST)
                  s_d.rst_en = 1'b1; // [R4]
            end
         end
         S_DEACT:
         begin
            if (osc_tick)
            begin
               s_d.cnt = cnt_nx; // [R12]
               if (cnt_nx == DE_RST)
                  s_d.rst_en = 1'b0; // [R7]
               if (cnt_nx == DE_CLK)
                  s_d.clk_en = 1'b0; // [R8]
               if (cnt_nx == DE_LINES)
                  s_d.line_lvl = 1'b0; // [R9]
               if (cnt_nx == DE_VCC)
               begin
                  s_d.vcc_en = 1'b0; // [R10]
                  s_d.st = S_FALL;
               end
            end
         end
         S_FALL:
         begin
            // Done only once the card supply has really collapsed
            if (vcc_below_i)
            begin
               s_d.st = S_IDLE; // [R10]
               s_d.cnt = '0;
               s_d.grounded = 1'b1; // [R11]
               s_d.line_oe = 1'b0;
               s_d.line_lvl = 1'b1;
               s_d.osc_fast = 1'b0;
               s_d.clk_en = 1'b0;
               s_d.rst_en = 1'b0;
            end
         end
      endcase
      // Status pin: presence, forced low by a latched session fault
      s_d.fault_n = present && !s_d.fault; // [R15] [R21]
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
         s_q <= SEQ_RST;
      else
         s_q <= s_d;
   end

   assign osc_fast_o = s_q.osc_fast;
   assign card_vcc_en_o = s_q.vcc_en;
   assign card_rst_en_o = s_q.rst_en;
   assign card_clk_en_o = s_q.clk_en;
   assign contacts_grounded_o = s_q.grounded;
   assign host_io_line_o = s_q.line_lvl;
   assign host_io_line_oe_o = s_q.line_oe;
   assign host_aux1_line_o = s_q.line_lvl;
   assign host_aux1_line_oe_o = s_q.line_oe;
   assign host_aux2_line_o = s_q.line_lvl;
   assign host_aux2_line_oe_o = s_q.line_oe;
   assign fault_status_n_o = s_q.fault_n;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   property p_wake_len;
      (s_q.st == S_WAKE && s_q.cnt == WAKE_LAST && slow_tick && !abort)
         |=> (s_q.st == S_ACT && osc_fast_o);
   endproperty
   a_wake_len: assert property (p_wake_len) // [R1]
      else $error("oscillator not fast at end of wake");

   property p_vcc_with_fast;
      (s_q.st == S_ACT && $rose(osc_fast_o)) |-> $rose(card_vcc_en_o);
   endproperty
   a_vcc_with_fast: assert property (p_vcc_with_fast) // [R2]
      else $error("card supply not raised with fast oscillator");

   property p_lines_high;
      $rose(host_io_line_oe_o) |->
         (s_q.st == S_ACT && s_q.cnt == ACT_LINES && host_aux2_line_o);
   endproperty
   a_lines_high: assert property (p_lines_high) // [R3]
      else $error("host lines driven at wrong step");

   property p_rst_on;
      $rose(card_rst_en_o) |-> (s_q.cnt == ACT_RST && host_io_line_oe_o);
   endproperty
   a_rst_on: assert property (p_rst_on) // [R4]
      else $error("card reset enabled at wrong step");

   property p_clk_off;
      (s_q.st == S_DEACT && $fell(card_clk_en_o)) |->
         (s_q.cnt == DE_CLK && !card_rst_en_o);
   endproperty
   a_clk_off: assert property (p_clk_off) // [R8]
      else $error("card clock stopped at wrong step");

   property p_lines_low;
      $fell(host_io_line_o) |-> (s_q.cnt == DE_LINES && !card_clk_en_o);
   endproperty
   a_lines_low: assert property (p_lines_low) // [R9]
      else $error("host lines pulled low at wrong step");

   property p_vcc_off;
      $fell(card_vcc_en_o) |-> (s_q.st == S_FALL && s_q.cnt == DE_VCC);
   endproperty
   a_vcc_off: assert property (p_vcc_off) // [R10]
      else $error("card supply dropped at wrong step");

   property p_idle_safe;
      (s_q.st == S_IDLE) |->
         (contacts_grounded_o && !osc_fast_o && !host_io_line_oe_o);
   endproperty
   a_idle_safe: assert property (p_idle_safe) // [R11]
      else $error("idle state not safe");

   property p_status_presence;
      (session_request_n_i && !s_q.fault && !session) |=>
         (fault_status_n_o == $past(present) || s_q.fault);
   endproperty
   a_status_presence: assert property (p_status_presence) // [R15]
      else $error("status does not follow presence");

   property p_fault_abort;
      (session && !session_request_n_i && fault_cond) |=>
         (s_q.st == S_DEACT && !fault_status_n_o);
   endproperty
   a_fault_abort: assert property (p_fault_abort) // [R17]
      else $error("fault did not start deactivation");

   property p_hold_exit;
      (s_q.st == S_HOLD && s_q.cnt != HOLD_LAST) |=> (s_q.st == S_HOLD);
   endproperty
   a_hold_exit: assert property (p_hold_exit) // [R22]
      else $error("shutdown hold left early");

   property p_hold_count;
      (s_q.st == S_IDLE && $past(s_q.st) == S_HOLD) |->
         ($past(s_q.cnt) == HOLD_LAST);
   endproperty
   a_hold_count: assert property (p_hold_count) // [R22]
      else $error("shutdown hold wrong length");
endmodule
`default_nettype wire

/* File: verilog/scss_pkg.sv */
// Constants, timing counts and state codes of the smart card session
// sequencer. Assumes a 250 MHz core clock and synchronous inputs.
// Behaviour
// R1 - Request fall: oscillator fast after 384 slow
// R2 - Card supply rises when oscillator goes fast
// R3 - Host lines driven high at 17T/2
// R4 - Card reset enabled at 23T/2
// R5 - T is 64 fast oscillator periods
// R6 - Host applies card clock between start, end
// R7 - Request rise: reset low after 3T/64
// R8 - Card clock stopped T/2 after reset low
// R9 - Host lines pulled low T after reset
// R10 - Supply drops at 3T/2, ends below 0.4V
// R11 - Idle: contacts grounded, lines weak, slow oscillator
// R12 - Deactivation T is 64 periods, about 25us
// R13 - Overcurrent filtered so short pulses pass
// R14 - Faults: overcurrent, removal, supply drops, overheat
// R15 - Outside session status follows card presence
// R16 - Outside session supply drop only resets internally
// R17 - Session fault starts emergency deactivation
// R18 - Request release after fault rechecks presence
// R19 - Presence debounced over 640 slow periods
// R20 - Insertion raises status after full debounce
// R21 - Extraction deactivates at once, then status low
// R22 - Power-up holds shutdown 1024 slow periods
// R23 - One counter times all steps, abort anywhere
package scss_pkg;
   localparam int CLK_MHZ = 250;
   localparam int HOLD_MS = 8;
   localparam int HOLD_PERIODS = 1024;
   localparam int T_US = 25;
   localparam int T_PERIODS = 64;
   // Oscillator periods in ns, then in core clock cycles (rounded down)
   localparam int SLOW_PER_NS = HOLD_MS * 1000000 / HOLD_PERIODS;
   localparam int FAST_PER_NS = T_US * 1000 / T_PERIODS;
   localparam logic [10:0] SLOW_DIV_LAST =
      11'(SLOW_PER_NS * CLK_MHZ / 1000 - 1);
   localparam logic [10:0] FAST_DIV_LAST =
      11'(FAST_PER_NS * CLK_MHZ / 1000 - 1);
   // Sequence points, in oscillator periods
   localparam logic [10:0] WAKE_LAST = 11'h17F;
   localparam logic [10:0] ACT_LINES = 11'(17 * T_PERIODS / 2);
   localparam logic [10:0] ACT_RST = 11'(23 * T_PERIODS / 2);
   localparam logic [10:0] DE_RST = 11'(3 * T_PERIODS / 64);
   localparam logic [10:0] DE_CLK = 11'(DE_RST + T_PERIODS / 2);
   localparam logic [10:0] DE_LINES = 11'(DE_RST + T_PERIODS);
   localparam logic [10:0] DE_VCC = 11'(DE_RST + 3 * T_PERIODS / 2);
   localparam logic [10:0] HOLD_LAST = 11'(HOLD_PERIODS - 1);
   localparam logic [10:0] DEB_LAST = 11'h27F;
   localparam logic [10:0] OC_FILT = 11'h100;

   typedef enum logic [5:0] {
      S_HOLD = 6'h01,
      S_IDLE = 6'h02,
      S_WAKE = 6'h04,
      S_ACT = 6'h08,
      S_DEACT = 6'h10,
      S_FALL = 6'h20
   } scss_state_t;
endpackage

/* File: verilog/scss_debounce.sv */
// Card presence filter: slow insertion acceptance, instant removal.
// Assumes tick_i is a one-cycle slow oscillator pulse.
`timescale 1ns/1ps
`default_nettype none
module scss_debounce
   import scss_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   input wire logic card_present_n_i,
   output logic present_o
);
   typedef struct packed {
      logic [10:0] cnt;
      logic present;
   } scss_deb_t;

   scss_deb_t s_q;
   scss_deb_t s_d;

   // Removal drops at once; insertion must stay stable for the full span
   always_comb
   begin
      s_d = s_q;
      if (card_present_n_i)
      begin
         s_d.present = 1'b0; // [R21]
         s_d.cnt = '0;
      end
      else if (!s_q.present && tick_i)
      begin
         if (s_q.cnt == DEB_LAST)
            s_d.present = 1'b1; // [R19] [R20]
         else
            s_d.cnt = s_q.cnt + 11'h001;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign present_o = s_q.present;
endmodule
`default_nettype wire

/* File: bench/scss_card_model.sv */
// Far-side model: card supply sensing and host card clock gating.
// Assumes the sequencer's enables and a free-running core clock.
`timescale 1ns/1ps
`default_nettype none
module scss_card_model
#(
   parameter int FALL_CYC = 40
)
(
   input wire logic core_clk_i,
   input wire logic card_vcc_en_i,
   input wire logic card_clk_en_i,
   input wire logic card_rst_en_i,
   output logic vcc_below_o,
   output logic card_clk_on_o
);
   int lag = 0;
   logic clk_on = 1'b0;
   // Supply decays slowly, so the low report lags the enable drop
   always @(posedge core_clk_i)
   begin
      if (card_vcc_en_i)
         lag <= 0;
      else if (lag < FALL_CYC)
         lag <= lag + 1;
   end
   assign vcc_below_o = !card_vcc_en_i && (lag >= FALL_CYC);
   // Host starts the clock one cycle after it is allowed, never once
   // reset is up, then keeps it running until permission drops
   always @(posedge core_clk_i)
   begin
      clk_on <= card_clk_en_i && (clk_on || !card_rst_en_i);
   end
   assign card_clk_on_o = clk_on;
endmodule
`default_nettype wire

/* File: bench/smart_card_session_sequencer_test.sv */
// Self-checking bench for the session sequencer.
// Assumes the card model; oscillator periods shortened, counts unchanged.
`timescale 1ns/1ps
`default_nettype none
module smart_card_session_sequencer_test;
   localparam int SUP_LAG = 40;
   localparam int SLOW = 16;
   localparam int FAST = 4;
   localparam int LIMIT = 70000;
   logic clk = 0, rstn = 0, req_n = 1, pres_n = 0, otemp = 0, ocur = 0;
   logic [2:0] drop = 3'h0;
   logic below, fast, vcc, rst, cke, gnd, io, io_oe, a1, a1_oe;
   logic a2, a2_oe, flt_n, clk_on;
   int err_total = 0, n_tests = 0, cyc = 0, t_rel = 0, n;
   always #2 clk = ~clk;
   scss_sequencer #(.SLOW_LAST(11'(SLOW - 1)), .FAST_LAST(11'(FAST - 1)))
      dut (.core_clk_i(clk), .rstn_i(rstn),
      .session_request_n_i(req_n), .card_present_n_i(pres_n),
      .overcurrent_i(ocur), .supply_drop_i(drop), .overtemp_i(otemp),
      .vcc_below_i(below), .osc_fast_o(fast), .card_vcc_en_o(vcc),
      .card_rst_en_o(rst), .card_clk_en_o(cke),
      .contacts_grounded_o(gnd), .host_io_line_o(io),
      .host_io_line_oe_o(io_oe), .host_aux1_line_o(a1),
      .host_aux1_line_oe_o(a1_oe), .host_aux2_line_o(a2),
      .host_aux2_line_oe_o(a2_oe), .fault_status_n_o(flt_n));
   scss_card_model #(.FALL_CYC(SUP_LAG)) card (.core_clk_i(clk),
      .card_vcc_en_i(vcc), .card_clk_en_i(cke), .card_rst_en_i(rst),
      .vcc_below_o(below), .card_clk_on_o(clk_on));
   task automatic finish_test();
      $display("counts: %0d checks, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard, sized to the long shutdown and wake counts
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_total++;
         finish_test();
      end
   end
   task automatic check_bit(string nm, logic e, logic g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic check_range(string nm, int g, int lo, int hi);
      n_tests++;
      if (g < lo || g > hi)
      begin
         err_total++;
         $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // Counts cycles until the chosen output reaches val, bounded by lim
   task automatic wait_sig(int sel, logic val, int lim, output int k);
      logic s;
      k = 0;
      do
      begin
         step();
         k++;
         case (sel)
            0: s = fast;
            1: s = rst;
            2: s = cke;
            3: s = io;
            4: s = vcc;
            5: s = io_oe;
            6: s = flt_n;
            default: s = gnd;
         endcase
      end
      while (s !== val && k < lim);
   endtask
   task automatic t_reset();
      repeat (6) step();
      check_bit("grounded", 1'b1, gnd);
      check_bit("io_oe", 1'b0, io_oe | a1_oe | a2_oe);
      check_bit("levels", 1'b1, io & a1 & a2);
      check_bit("enables", 1'b0, fast | vcc | rst | cke | flt_n);
      rstn = 1;
      t_rel = cyc;
      $display("test reset done");
   endtask
   task automatic t_insert_hold();
      wait_sig(6, 1'b1, 1300000, n);
      check_range("debounce", n, 639 * SLOW, 641 * SLOW + 3);
      // Refused: request falls in the hold and stays low past its end
      req_n = 0;
      while (cyc - t_rel < 1030 * SLOW)
         step();
      check_bit("hold_fast", 1'b0, fast);
      req_n = 1;
      step();
      $display("test insert_hold done");
   endtask
   task automatic t_act();
      req_n = 0;
      wait_sig(0, 1'b1, 800000, n);
      check_range("wake", n, 383 * SLOW, 385 * SLOW + 3);
      check_bit("vcc_rise", 1'b1, vcc);
      wait_sig(5, 1'b1, 60000, n);
      check_range("start", n, 543 * FAST, 545 * FAST + 3);
      check_bit("lines_hi", 1'b1, io & a1 & a2 & a1_oe & a2_oe);
      check_bit("clk_early", 1'b0, clk_on);
      wait_sig(1, 1'b1, 20000, n);
      check_range("end", n, 192 * FAST - 3, 192 * FAST + 3);
      check_bit("clk_on", 1'b1, clk_on);
      $display("test activation done");
   endtask
   task automatic t_deact();
      req_n = 1;
      wait_sig(1, 1'b0, 1000, n);
      check_range("rst_low", n, 2 * FAST, 4 * FAST + 3);
      wait_sig(2, 1'b0, 5000, n);
      check_range("clk_stop", n, 32 * FAST - 3, 32 * FAST + 3);
      wait_sig(3, 1'b0, 5000, n);
      check_range("lines_low", n, 32 * FAST - 3, 32 * FAST + 3);
      check_bit("lines_oe", 1'b1, io_oe);
      check_bit("clk_off", 1'b0, clk_on);
      wait_sig(4, 1'b0, 5000, n);
      check_range("vcc_fall", n, 32 * FAST - 3, 32 * FAST + 3);
      wait_sig(7, 1'b1, 200, n);
      check_range("deac", n, SUP_LAG, SUP_LAG + 3);
      check_bit("idle_oe", 1'b0, io_oe | a1_oe | a2_oe | fast);
      check_bit("idle_lvl", 1'b1, io & a1 & a2);
      $display("test deactivation done");
   endtask
   // Overheat and each supply drop bit abort a session still in its wake phase
   task automatic t_faults();
      for (int k = 0; k < 4; k++)
      begin
         req_n = 0;
         repeat (100) step();
         if (k == 0)
            otemp = 1;
         else
            drop[k - 1] = 1;
         wait_sig(6, 1'b0, 5, n);
         check_range("fault_n", n, 1, 3);
         repeat (2) step();
         check_bit("abort_fast", 1'b1, fast);
         wait_sig(0, 1'b0, 20000, n);
         check_range("abort", n, 96 * FAST, 100 * FAST + SUP_LAG + 5);
         check_bit("abort_rst", 1'b0, rst | vcc);
         otemp = 0;
         drop = 3'h0;
         req_n = 1;
         wait_sig(6, 1'b1, 5, n);
         check_range("recheck", n, 1, 3);
      end
      $display("test faults done");
   endtask
   // Overload filter in a session, then extraction and reinsertion
   task automatic t_overload();
      req_n = 0;
      repeat (100) step();
      ocur = 1;
      repeat (200 * SLOW) step();
      ocur = 0;
      check_bit("short_load", 1'b1, flt_n);
      step();
      ocur = 1;
      wait_sig(6, 1'b0, 300 * SLOW, n);
      check_range("long_load", n, 255 * SLOW, 256 * SLOW + 3);
      wait_sig(0, 1'b0, 2000, n);
      ocur = 0;
      req_n = 1;
      wait_sig(6, 1'b1, 5, n);
      check_range("load_recheck", n, 1, 3);
      req_n = 0;
      repeat (100) step();
      pres_n = 1;
      wait_sig(6, 1'b0, 5, n);
      check_range("extract", n, 1, 3);
      wait_sig(0, 1'b0, 2000, n);
      check_bit("extract_rst", 1'b0, rst | vcc);
      pres_n = 0;
      req_n = 1;
      wait_sig(6, 1'b1, 700 * SLOW, n);
      check_range("reinsert", n, 639 * SLOW, 641 * SLOW + 3);
      $display("test overload done");
   endtask
   task automatic t_idle();
      drop = 3'h1;
      repeat (5) step();
      drop = 3'h0;
      wait_sig(6, 1'b0, 50, n);
      check_range("idle_drop", n, 50, 50);
      check_bit("idle_drop_n", 1'b1, flt_n);
      pres_n = 1;
      wait_sig(6, 1'b0, 5, n);
      check_range("removal", n, 1, 3);
      $display("test idle done");
   endtask
   initial
   begin
      t_reset();
      t_insert_hold();
      t_act();
      t_deact();
      t_faults();
      t_overload();
      t_idle();
      finish_test();
   end
endmodule
`default_nettype wire
